// [design/dct_timer.sv]
// Two-channel 8-bit timer with compare-match, overflow, clear modes and output control
//
// Local design decision: the plain strobed port.
module dct_timer
    import dct_timer_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    // Power mode
    input  wire logic        i_standby,
    // Register port
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    // Timer pins, one bit per channel
    input  wire logic [1:0]  i_ext_count_clock_pin,
    input  wire logic [1:0]  i_ext_counter_reset_pin,
    output logic      [1:0]  o_timer_out_pin,
    output logic      [1:0]  o_timer_out_en,
    // Interrupt requests, one bit per channel
    output logic      [1:0]  o_match_a_irq,
    output logic      [1:0]  o_match_b_irq,
    output logic      [1:0]  o_wrap_irq
);

    dct_state_s r;      // Registered state
    dct_state_s n;      // Next state

    // Decode the clock-select field into a counting source
    function automatic dct_src_e decode_src(input logic [2:0] cks);
        dct_src_e s;
        s = DCT_SRC_STOP;
        unique case (cks)
            3'h1, 3'h2, 3'h3: s = DCT_SRC_INT;
            3'h5:             s = DCT_SRC_EXT_RISE;
            3'h6:             s = DCT_SRC_EXT_FALL;
            3'h7:             s = DCT_SRC_EXT_BOTH;
            3'h0, 3'h4:       s = DCT_SRC_STOP;
        endcase
        return s;
    endfunction

    // A divided clock falls when all its low prescaler bits are one and roll over
    function automatic logic div_fall(input logic [`DCT_PRESC_W-1:0] p, input logic [`DCT_PRESC_W-1:0] m);
        return (p & m) == m;
    endfunction

    // Pick the divider mask for a channel; the shared bit chooses within each pair
    function automatic logic [`DCT_PRESC_W-1:0] div_mask(input logic ch, input logic [1:0] cks, input logic pick);
        logic [`DCT_PRESC_W-1:0] m;
        m = `DCT_DIV8;
        unique case (cks)
            2'h1: m = pick ? `DCT_DIV2 : `DCT_DIV8;
            2'h2: m = pick ? (ch ? `DCT_DIV128 : `DCT_DIV32) : `DCT_DIV64;
            2'h3: m = pick ? (ch ? `DCT_DIV2048 : `DCT_DIV256) : `DCT_DIV1024;
            2'h0: m = `DCT_DIV8;                        // Unused: source is stopped
        endcase
        return m;
    endfunction

    // Next-state logic for both channels and the register port
    always_comb begin
        logic [15:0] a_ctl;     // Per-channel addresses
        logic [15:0] a_csr;
        logic [15:0] a_ca;
        logic [15:0] a_cb;
        logic [15:0] a_cnt;
        logic        tick;      // Count pulse this cycle
        logic        ma;        // Compare-match A event
        logic        mb;        // Compare-match B event
        logic        ext_rst;   // Rising edge of external reset
        logic        clr;       // Counter clear request
        logic        wrap;      // Counter rolls from ff to 00
        logic [2:0]  set;       // Flag set events {b, a, wrap}
        logic [1:0]  osa;       // Action on match A
        logic [1:0]  osb;       // Action on match B
        logic [7:0]  rd_val;    // Read mux
        dct_src_e    src;

        n       = r;
        a_ctl   = 16'h0000;
        a_csr   = 16'h0000;
        a_ca    = 16'h0000;
        a_cb    = 16'h0000;
        a_cnt   = 16'h0000;
        tick    = 1'b0;
        ma      = 1'b0;
        mb      = 1'b0;
        ext_rst = 1'b0;
        clr     = 1'b0;
        wrap    = 1'b0;
        set     = 3'h0;
        osa     = 2'h0;
        osb     = 2'h0;
        rd_val  = 8'h00;
        src     = DCT_SRC_STOP;

        // Prescaler runs from the system clock at all times outside standby, which holds it at zero
        n.presc = r.presc + `DCT_PRESC_W'(1);

        // Pins pass two flip-flops before any edge logic looks at them
        n.ck_s1 = i_ext_count_clock_pin;
        n.ck_s2 = r.ck_s1;
        n.ck_s3 = r.ck_s2;
        n.rs_s1 = i_ext_counter_reset_pin;
        n.rs_s2 = r.rs_s1;
        n.rs_s3 = r.rs_s2;

        // Shared control register serves both channels
        if (i_wr && i_addr == `DCT_ADDR_SHARED_SERIAL_TIMER_CONTROL) begin
            n.shared_serial_timer_control = i_wdata;
        end
        if (i_addr == `DCT_ADDR_SHARED_SERIAL_TIMER_CONTROL) begin
            rd_val = r.shared_serial_timer_control;
        end

        for (int ch = 0; ch < 2; ch++) begin
            // Channel register addresses
            a_ctl = (ch == 1) ? `DCT_ADDR_CTL1 : `DCT_ADDR_CTL0;
            a_csr = (ch == 1) ? `DCT_ADDR_CSR1 : `DCT_ADDR_CSR0;
            a_ca  = (ch == 1) ? `DCT_ADDR_CA1  : `DCT_ADDR_CA0;
            a_cb  = (ch == 1) ? `DCT_ADDR_CB1  : `DCT_ADDR_CB0;
            a_cnt = (ch == 1) ? `DCT_ADDR_CNT1 : `DCT_ADDR_CNT0;

            // Count pulse from the selected source
            src = decode_src(r.ctl[ch][`DCT_CKS_MSB:`DCT_CKS_LSB]);
            unique case (src)
                DCT_SRC_INT: begin
                    tick = div_fall(r.presc, div_mask(1'(ch), r.ctl[ch][1:0], r.shared_serial_timer_control[ch]));
                end
                DCT_SRC_EXT_RISE: begin
                    tick = r.ck_s2[ch] & ~r.ck_s3[ch];
                end
                DCT_SRC_EXT_FALL: begin
                    tick = ~r.ck_s2[ch] & r.ck_s3[ch];
                end
                DCT_SRC_EXT_BOTH: begin
                    tick = r.ck_s2[ch] ^ r.ck_s3[ch];
                end
                DCT_SRC_STOP: begin
                    tick = 1'b0;
                end
            endcase

            // Compare on each count pulse; a write to the constant masks its match
            ma = tick && (r.cnt[ch] == r.ca[ch]) && !(i_wr && i_addr == a_ca);
            mb = tick && (r.cnt[ch] == r.cb[ch]) && !(i_wr && i_addr == a_cb);

            // Counter clear source
            ext_rst = r.rs_s2[ch] & ~r.rs_s3[ch];
            unique case (r.ctl[ch][`DCT_CCLR_MSB:`DCT_CCLR_LSB])
                `DCT_CLR_NONE: clr = 1'b0;
                `DCT_CLR_MA:   clr = ma;
                `DCT_CLR_MB:   clr = mb;
                `DCT_CLR_EXT:  clr = ext_rst;
            endcase

            // Counter: clear beats a CPU write, a CPU write beats a count
            wrap = 1'b0;
            if (clr) begin
                n.cnt[ch] = `DCT_CNT_RESET;
            end else if (i_wr && i_addr == a_cnt) begin
                n.cnt[ch] = i_wdata;
            end else if (tick) begin
                n.cnt[ch] = r.cnt[ch] + 8'h01;
                wrap      = (r.cnt[ch] == 8'hff);
            end

            // Control and constant writes
            if (i_wr && i_addr == a_ctl) begin
                n.ctl[ch] = i_wdata;
            end
            if (i_wr && i_addr == a_ca) begin
                n.ca[ch] = i_wdata;
            end
            if (i_wr && i_addr == a_cb) begin
                n.cb[ch] = i_wdata;
            end

            // Reading the status register arms every flag that is set at that moment
            if (i_rd && i_addr == a_csr) begin
                n.armed[ch] = r.armed[ch] | r.flg[ch];
            end

            // Status write: zero clears an armed flag, one is ignored, bit 4 is fixed
            if (i_wr && i_addr == a_csr) begin
                n.os[ch] = i_wdata[`DCT_OSA_MSB+2:`DCT_OSA_LSB];
                n.flg[ch] = r.flg[ch] & ~(~i_wdata[`DCT_FLG_MSB:`DCT_FLG_LSB] & r.armed[ch]);
                n.armed[ch] = 3'h0;
            end

            // Hardware events win over a clear in the same cycle
            set = {mb, ma, wrap};
            n.flg[ch] = n.flg[ch] | set;

            // Output action: toggle beats one, one beats zero
            osa = r.os[ch][`DCT_OSA_MSB:`DCT_OSA_LSB];
            osb = r.os[ch][`DCT_OSB_MSB:`DCT_OSB_LSB];
            if ((ma && osa == `DCT_OS_TOGGLE) || (mb && osb == `DCT_OS_TOGGLE)) begin
                n.timer_out_pin[ch] = ~r.timer_out_pin[ch];
            end else if ((ma && osa == `DCT_OS_ONE) || (mb && osb == `DCT_OS_ONE)) begin
                n.timer_out_pin[ch] = 1'b1;
            end else if ((ma && osa == `DCT_OS_ZERO) || (mb && osb == `DCT_OS_ZERO)) begin
                n.timer_out_pin[ch] = 1'b0;
            end

            // Read mux for this channel
            if (i_addr == a_ctl) begin
                rd_val = r.ctl[ch];
            end else if (i_addr == a_csr) begin
                rd_val = {r.flg[ch], `DCT_RSVD_ONE, r.os[ch]};
            end else if (i_addr == a_ca) begin
                rd_val = r.ca[ch];
            end else if (i_addr == a_cb) begin
                rd_val = r.cb[ch];
            end else if (i_addr == a_cnt) begin
                rd_val = r.cnt[ch];
            end
        end

        // Read data stand only in the cycle after the read strobe; unmapped reads give zero
        n.rdata = i_rd ? rd_val : 8'h00;

        // Standby holds every register except read data and pin synchronisers at reset values; writes are lost meanwhile
        if (i_standby) begin
            n.presc = '0;
            n.shared_serial_timer_control  = `DCT_SHARED_SERIAL_TIMER_CONTROL_RESET;
            n.ctl   = {2{`DCT_CTL_RESET}};
            n.os    = '0;
            n.flg   = '0;
            n.armed = '0;
            n.ca    = {2{`DCT_COR_RESET}};
            n.cb    = {2{`DCT_COR_RESET}};
            n.cnt   = {2{`DCT_CNT_RESET}};
            n.timer_out_pin   = '0;
        end
    end

    // State register; asynchronous reset loads only constants
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r      <= '0;
            r.shared_serial_timer_control <= `DCT_SHARED_SERIAL_TIMER_CONTROL_RESET;
            r.ctl  <= {2{`DCT_CTL_RESET}};
            r.ca   <= {2{`DCT_COR_RESET}};
            r.cb   <= {2{`DCT_COR_RESET}};
            r.cnt  <= {2{`DCT_CNT_RESET}};
        end else begin
            r <= n;
        end
    end

    // Outputs: data from flip-flops, interrupt levels from flag and enable
    always_comb begin
        o_rdata         = r.rdata;
        o_timer_out_pin = r.timer_out_pin;
        for (int ch = 0; ch < 2; ch++) begin
            // Output function is off while all four select bits are zero
            o_timer_out_en[ch] = |r.os[ch];
            o_match_b_irq[ch]  = r.flg[ch][2] & r.ctl[ch][`DCT_BIT_IE_B];
            o_match_a_irq[ch]  = r.flg[ch][1] & r.ctl[ch][`DCT_BIT_IE_A];
            o_wrap_irq[ch]     = r.flg[ch][0] & r.ctl[ch][`DCT_BIT_IE_W];
        end
    end

endmodule

// [design/dct_timer_cfg.svh]
// Register map, field positions, reset values and prescaler figures of the dual 8-bit timer
`ifndef DCT_TIMER_CFG_SVH
`define DCT_TIMER_CFG_SVH

// Register addresses
`define DCT_ADDR_SHARED_SERIAL_TIMER_CONTROL 16'hffc3
`define DCT_ADDR_CTL0 16'hffc8
`define DCT_ADDR_CSR0 16'hffc9
`define DCT_ADDR_CA0  16'hffca
`define DCT_ADDR_CB0  16'hffcb
`define DCT_ADDR_CNT0 16'hffcc
`define DCT_ADDR_CTL1 16'hffd0
`define DCT_ADDR_CSR1 16'hffd1
`define DCT_ADDR_CA1  16'hffd2
`define DCT_ADDR_CB1  16'hffd3
`define DCT_ADDR_CNT1 16'hffd4

// Control register fields
`define DCT_BIT_IE_B   7
`define DCT_BIT_IE_A   6
`define DCT_BIT_IE_W   5
`define DCT_CCLR_MSB   4
`define DCT_CCLR_LSB   3
`define DCT_CKS_MSB    2
`define DCT_CKS_LSB    0

// Control/status register fields
`define DCT_FLG_MSB    7
`define DCT_FLG_LSB    5
`define DCT_OSB_MSB    3
`define DCT_OSB_LSB    2
`define DCT_OSA_MSB    1
`define DCT_OSA_LSB    0
`define DCT_RSVD_ONE   1'h1

// Reset values
`define DCT_CTL_RESET  8'h00
`define DCT_CSR_RESET  8'h10
`define DCT_COR_RESET  8'hff
`define DCT_CNT_RESET  8'h00
`define DCT_SHARED_SERIAL_TIMER_CONTROL_RESET 8'h00

// Counter clear modes
`define DCT_CLR_NONE   2'h0
`define DCT_CLR_MA     2'h1
`define DCT_CLR_MB     2'h2
`define DCT_CLR_EXT    2'h3

// Output actions per compare-match
`define DCT_OS_ZERO    2'h1
`define DCT_OS_ONE     2'h2
`define DCT_OS_TOGGLE  2'h3

// Prescaler: width and low-bit masks whose all-ones marks a falling edge of the divided clock
`define DCT_PRESC_W    11
`define DCT_DIV2       11'h001
`define DCT_DIV8       11'h007
`define DCT_DIV32      11'h01f
`define DCT_DIV64      11'h03f
`define DCT_DIV128     11'h07f
`define DCT_DIV256     11'h0ff
`define DCT_DIV1024    11'h3ff
`define DCT_DIV2048    11'h7ff

`endif

// [design/dct_timer_pkg.sv]
// Types shared by the dual 8-bit timer
package dct_timer_pkg;
`include "dct_timer_cfg.svh"

    // Counting source decoded from the clock-select field
    typedef enum logic [2:0] {
        DCT_SRC_STOP,
        DCT_SRC_INT,
        DCT_SRC_EXT_RISE,
        DCT_SRC_EXT_FALL,
        DCT_SRC_EXT_BOTH
    } dct_src_e;

    // Whole state of the timer block
    typedef struct packed {
        logic [`DCT_PRESC_W-1:0] presc;     // Free-running prescaler
        logic [7:0]              shared_serial_timer_control;      // Shared serial/timer control
        logic [1:0][7:0]         ctl;       // Channel control registers
        logic [1:0][3:0]         os;        // Output-select bits
        logic [1:0][2:0]         flg;       // {match_b, match_a, wrap} flags
        logic [1:0][2:0]         armed;     // Flag seen set by a read
        logic [1:0][7:0]         ca;        // Time constant A
        logic [1:0][7:0]         cb;        // Time constant B
        logic [1:0][7:0]         cnt;       // Counters
        logic [1:0]              timer_out_pin;       // Timer output levels
        logic [1:0]              ck_s1;     // External clock sync stage 1
        logic [1:0]              ck_s2;     // External clock sync stage 2
        logic [1:0]              ck_s3;     // External clock edge history
        logic [1:0]              rs_s1;     // External reset sync stage 1
        logic [1:0]              rs_s2;     // External reset sync stage 2
        logic [1:0]              rs_s3;     // External reset edge history
        logic [7:0]              rdata;     // Read data register
    } dct_state_s;

endpackage

// [verification/dct_pin_drv.sv]
// Board-side driver of the external count and reset pins of both channels
module dct_pin_drv (
    // Pins toward the timer, one bit per channel
    output logic [1:0] o_clk_pin,
    output logic [1:0] o_rst_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // Both lines rest low between bursts, never floating
    initial begin
        o_clk_pin = 2'h0;
        o_rst_pin = 2'h0;
    end

    // Burst of n pulses; half period unrelated to the system clock
    task automatic pulses(input int ch, input int n, input int half);
        repeat (n) begin
            #(half) o_clk_pin[ch] = 1'b1;
            #(half) o_clk_pin[ch] = 1'b0;
        end
    endtask

    // Single reset pulse, wide enough to pass the synchroniser
    task automatic rst_pulse(input int ch);
        #(173) o_rst_pin[ch] = 1'b1;
        #(400) o_rst_pin[ch] = 1'b0;
    endtask
endmodule

// [verification/dct_timer_asserts.sv]
// Port-level checker of the dual 8-bit timer
module dct_timer_asserts (
    // Clock, reset and mode
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    input wire logic        i_standby,
    // Register port
    input wire logic [15:0] i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [7:0]  o_rdata,
    // Output pins and requests
    input wire logic [1:0]  o_timer_out_pin,
    input wire logic [1:0]  o_timer_out_en,
    input wire logic [1:0]  o_match_a_irq,
    input wire logic [1:0]  o_match_b_irq,
    input wire logic [1:0]  o_wrap_irq
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    chk_rdata_idle:
        assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data outside read slot");
    chk_csr_fixed:
        assert property ($past(i_rd) && $past(i_addr) inside {16'hffc9, 16'hffd1} |-> o_rdata[4])
        else $error("status bit 4 read as zero");
    // Plain registers read back what was written two cycles earlier
    chk_rw_readback:
        assert property ($past(i_wr, 3) && $past(i_rd) && $past(i_addr) == $past(i_addr, 3)
            && $past(i_addr) inside {16'hffc3, 16'hffc8, 16'hffca, 16'hffcb, 16'hffd0, 16'hffd2, 16'hffd3}
            && !($past(i_standby) || $past(i_standby, 2) || $past(i_standby, 3))
            |-> o_rdata == $past(i_wdata, 3)) else $error("register read back differs");
    chk_stby_const:
        assert property ($past(i_standby, 2) && $past(i_standby) && $past(i_rd)
            && $past(i_addr) inside {16'hffca, 16'hffcb, 16'hffd2, 16'hffd3} |-> o_rdata == 8'hff)
        else $error("constant not all ones in standby");
    chk_stby_quiet:
        assert property ($past(i_standby) |-> o_timer_out_en == 2'h0 && o_match_a_irq == 2'h0
            && o_match_b_irq == 2'h0 && o_wrap_irq == 2'h0) else $error("request or enable in standby");
    // A request only drops through a register write or standby
    chk_irqa_hold:
        assert property ($fell(o_match_a_irq[0]) |-> $past(i_standby)
            || $past(i_wr) && $past(i_addr) inside {16'hffc8, 16'hffc9}) else $error("match A request dropped");
    chk_irqb_hold:
        assert property ($fell(o_match_b_irq[0]) |-> $past(i_standby)
            || $past(i_wr) && $past(i_addr) inside {16'hffc8, 16'hffc9}) else $error("match B request dropped");
    chk_wrap_hold:
        assert property ($fell(o_wrap_irq[0]) |-> $past(i_standby)
            || $past(i_wr) && $past(i_addr) inside {16'hffc8, 16'hffc9}) else $error("wrap request dropped");
    chk_out_cause:
        assert property ($changed(o_timer_out_pin[0]) |-> $past(o_timer_out_en[0]) || $past(i_standby))
        else $error("output moved while disabled");
endmodule

bind dct_timer dct_timer_asserts i_dct_timer_asserts (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_standby(i_standby), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_timer_out_pin(o_timer_out_pin), .o_timer_out_en(o_timer_out_en),
    .o_match_a_irq(o_match_a_irq), .o_match_b_irq(o_match_b_irq), .o_wrap_irq(o_wrap_irq));

// [verification/tb_top.sv]
// Self-checking bench of the dual 8-bit timer
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // Design inputs, all defined at time zero
    logic        i_clock   = 1'b0;
    logic        i_rst_n   = 1'b0;
    logic        i_standby = 1'b0;
    logic [15:0] i_addr    = 16'h0000;
    logic [7:0]  i_wdata   = 8'h00;
    logic        i_wr      = 1'b0;
    logic        i_rd      = 1'b0;
    // Design outputs and pins
    logic [7:0]  o_rdata;
    logic [1:0]  ck_pin, rs_pin, o_timer_out_pin, o_timer_out_en, o_match_a_irq, o_match_b_irq, o_wrap_irq;
    logic [2:0]  irq0;
    // Bench state
    int          bad_count  = 0;
    int          n_compared = 0;
    logic [31:0] seed       = 32'h53ae172d;
    logic [7:0]  q, d;
    int          dv [2][6]  = '{'{8, 2, 64, 32, 1024, 256}, '{8, 2, 64, 128, 1024, 2048}};
    logic [15:0] regs [12]  = '{16'hffc3, 16'hffc8, 16'hffc9, 16'hffca, 16'hffcb, 16'hffcc,
                                16'hffd0, 16'hffd1, 16'hffd2, 16'hffd3, 16'hffd4, 16'hffc0};
    logic [15:0] rw [9]     = '{16'hffc3, 16'hffc8, 16'hffc9, 16'hffca, 16'hffcb, 16'hffcc,
                                16'hffd0, 16'hffd2, 16'hffd4};

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

    // Channel 0 requests as {wrap, B, A}
    assign irq0 = {o_wrap_irq[0], o_match_b_irq[0], o_match_a_irq[0]};

    always #25 i_clock = ~i_clock;

    dct_timer i_dct_timer (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_standby(i_standby), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_count_clock_pin(ck_pin),
        .i_ext_counter_reset_pin(rs_pin), .o_timer_out_pin(o_timer_out_pin), .o_timer_out_en(o_timer_out_en),
        .o_match_a_irq(o_match_a_irq), .o_match_b_irq(o_match_b_irq), .o_wrap_irq(o_wrap_irq));
    dct_pin_drv i_dct_pin_drv (.o_clk_pin(ck_pin), .o_rst_pin(rs_pin));

    // Next value of the stimulus sequence
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Reset value by address; unmapped places read zero
    function automatic logic [7:0] rst_val(input logic [15:0] a);
        if (a inside {16'hffc9, 16'hffd1}) return 8'h10;
        if (a inside {16'hffca, 16'hffcb, 16'hffd2, 16'hffd3}) return 8'hff;
        return 8'h00;
    endfunction

    // One access with a gap cycle after it; read data lands in q
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] dt);
        i_wr <= w;
        i_rd <= !w;
        i_addr <= a;
        i_wdata <= dt;
        @(posedge i_clock);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        #1 q = o_rdata;
        @(posedge i_clock);
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Bounded wait for one channel 0 request
    task automatic wait_irq(input int b);
        int k;
        k = 0;
        do begin
            @(posedge i_clock);
            #1 k++;
        end while (k < 600 && irq0[b] !== 1'b1);
        if (k >= 600) begin
            $display("MISMATCH %0t request wait ran out", $time);
            bad_count++;
            tally_and_finish();
        end
    endtask

    task automatic chk_map();
        foreach (regs[i]) begin
            acc(1'b0, regs[i], 8'h00);
            `CHK(q, rst_val(regs[i]))
        end
    endtask

    initial begin
        repeat (16) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        chk_map();
        // Random write and read back; control keeps a stop code
        foreach (rw[i]) begin
            seed = lfsr(seed);
            d = seed[7:0] & (rw[i][3:0] inside {4'h8, 4'h0} ? 8'he4 : 8'hff);
            acc(1'b1, rw[i], d);
            acc(1'b0, rw[i], 8'h00);
            `CHK(q, rw[i] == 16'hffc9 ? {4'h1, d[3:0]} : d)
            if (rw[i] == 16'hffc9) `CHK(o_timer_out_en[0], |d[3:0])
        end
        // Standby forces reset values and swallows writes
        i_standby <= 1'b1;
        repeat (2) @(posedge i_clock);
        acc(1'b0, 16'hffca, 8'h00);
        `CHK(q, 8'hff)
        acc(1'b1, 16'hffcb, 8'h12);
        i_standby <= 1'b0;
        @(posedge i_clock);
        chk_map();
        // Match B sets the pin, match A toggles it and clears the count
        acc(1'b1, 16'hffc3, 8'h01);
        acc(1'b1, 16'hffca, 8'h03);
        acc(1'b1, 16'hffcb, 8'h01);
        acc(1'b1, 16'hffc9, 8'h0b);
        acc(1'b1, 16'hffc8, 8'hc9);
        wait_irq(1);
        `CHK(o_timer_out_pin[0], 1'b1)
        wait_irq(0);
        `CHK(o_timer_out_pin[0], 1'b0)
        acc(1'b1, 16'hffc8, 8'hc0);
        acc(1'b0, 16'hffcc, 8'h00);
        `CHK(q, 8'h00)
        // Flags clear only by zero after a read that saw them set
        acc(1'b1, 16'hffc9, 8'h0b);
        `CHK(irq0, 3'b011)
        acc(1'b0, 16'hffc9, 8'h00);
        `CHK(q, 8'hdb)
        acc(1'b1, 16'hffc9, 8'hbb);
        `CHK(irq0, 3'b010)
        acc(1'b0, 16'hffc9, 8'h00);
        acc(1'b1, 16'hffc9, 8'h0b);
        `CHK(irq0, 3'b000)
        // Wrap from ff to 00
        acc(1'b1, 16'hffcc, 8'hfe);
        acc(1'b1, 16'hffc8, 8'h21);
        wait_irq(2);
        acc(1'b1, 16'hffc8, 8'h20);
        acc(1'b0, 16'hffcc, 8'h00);
        `CHK(q, 8'h00)
        acc(1'b0, 16'hffc9, 8'h00);
        `CHK(q, 8'h3b)
        acc(1'b1, 16'hffc9, 8'h0b);
        `CHK(irq0, 3'b000)
        // External clock on rising, falling and both edges
        for (int m = 5; m < 8; m++) begin
            acc(1'b1, 16'hffd4, 8'h00);
            acc(1'b1, 16'hffd0, m[7:0]);
            i_dct_pin_drv.pulses(1, 5, m == 6 ? 311 : 137);
            repeat (6) @(posedge i_clock);
            acc(1'b1, 16'hffd0, 8'h00);
            acc(1'b0, 16'hffd4, 8'h00);
            `CHK(q, m == 7 ? 8'h0a : 8'h05)
        end
        // External reset edge clears the counter
        acc(1'b1, 16'hffd4, 8'h40);
        acc(1'b1, 16'hffd0, 8'h18);
        i_dct_pin_drv.rst_pulse(1);
        repeat (4) @(posedge i_clock);
        acc(1'b0, 16'hffd4, 8'h00);
        `CHK(q, 8'h00)
        // Channel 1 match A on external rising edges toggles its pin and raises its request
        acc(1'b1, 16'hffd2, 8'h02);
        acc(1'b1, 16'hffd1, 8'h03);
        acc(1'b1, 16'hffd0, 8'h45);
        i_dct_pin_drv.pulses(1, 4, 137);
        repeat (6) @(posedge i_clock);
        #1;
        `CHK(o_timer_out_pin[1], 1'b1)
        `CHK(o_match_a_irq[1], 1'b1)
        acc(1'b1, 16'hffd0, 8'h00);
        // Every divisor counts four pulses in four periods; code 100 stays still
        for (int ch = 0; ch < 2; ch++) begin
            for (int k = 0; k < 7; k++) begin
                acc(1'b1, 16'hffcc + 16'(ch * 8), 8'h00);
                acc(1'b1, 16'hffc3, k[0] ? 8'h03 : 8'h00);
                acc(1'b1, 16'hffc8 + 16'(ch * 8), k == 6 ? 8'h04 : 8'(k / 2 + 1));
                repeat (4 * (k == 6 ? 8 : dv[ch][k]) - 2) @(posedge i_clock);
                acc(1'b1, 16'hffc8 + 16'(ch * 8), 8'h00);
                acc(1'b0, 16'hffcc + 16'(ch * 8), 8'h00);
                `CHK(q, k == 6 ? 8'h00 : 8'h04)
            end
        end
        tally_and_finish();
    end
endmodule
